// file: verilog/jktf_top.sv
// jk/toggle flop family: configurable cell behind an apb register set
//
// How it works
// - async preset forces output one immediately
// - jk pairs hold, clear, set, invert
// - gate low ignores edges, holds state
// - clear-priority: sync clear wins over set
// - set-priority: sync set wins over clear
// - sync clear ignores requests and gate
// - ungated toggle inverts when request high
// - async clear forces zero, overrides all
// - gated toggle needs request and gate
// - load with override ignores gate
// - load without override needs gate
// - toggle only when load low, gate high
// - power-on and init net give zero
// - preset variants init to one instead
`timescale 1ns/1ps
`include "jktf_consts.svh"
module jktf_top #(
  parameter bit TOGGLE_MODE = 1'b0,
  parameter bit ASYNC_PRESET = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_wide_init,
  output logic state_q
);
  jktf_pkg::jktf_top_st_t st_r;
  jktf_pkg::jktf_top_st_t st_nxt;
  jktf_pkg::jktf_cfg_t cfg;
  logic init_net;
  logic wr_acc;
  logic rd_acc;
  logic [11:0] addr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign addr = paddr[11:0];
  assign wr_acc = psel & penable & pwrite & st_r.pready_r;
  assign rd_acc = psel & ~penable & ~pwrite;

  // options come from one control word, ORed with TOGGLE_MODE and ASYNC_PRESET
  always_comb begin
    cfg.toggle_mode = st_r.ctrl_r[`JKTF_CTRL_MODE_BIT] | TOGGLE_MODE;
    cfg.async_preset = st_r.ctrl_r[`JKTF_CTRL_ASYNC_BIT] | ASYNC_PRESET;
    cfg.set_first = st_r.ctrl_r[`JKTF_CTRL_PRIO_BIT];
    cfg.has_gate = st_r.ctrl_r[`JKTF_CTRL_GATE_BIT];
    cfg.has_load = st_r.ctrl_r[`JKTF_CTRL_LOAD_BIT];
    cfg.load_over_gate = st_r.ctrl_r[`JKTF_CTRL_OVR_BIT];
    cfg.has_sync = st_r.ctrl_r[`JKTF_CTRL_SYNC_BIT];
  end

  // bus reset also reproduces power-on state
  assign init_net = chip_wide_init | ~presetn;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pready_r = psel & ~penable;
    if (wr_acc) begin
      if (hit(addr, `JKTF_REG_CTRL)) begin
        st_nxt.ctrl_r = pwdata[6:0];
      end else if (hit(addr, `JKTF_REG_INPUTS)) begin
        st_nxt.in_r = pwdata[8:0];
      end
    end
    if (rd_acc) begin
      if (hit(addr, `JKTF_REG_CTRL)) begin
        st_nxt.prdata_r = {25'h000_0000, st_r.ctrl_r};
      end else if (hit(addr, `JKTF_REG_INPUTS)) begin
        st_nxt.prdata_r = {23'h00_0000, st_r.in_r};
      end else if (hit(addr, `JKTF_REG_STATE)) begin
        st_nxt.prdata_r = {31'h0000_0000, state_q};
      end else if (hit(addr, `JKTF_REG_CONFIG)) begin
        st_nxt.prdata_r = {30'h0000_0000, ASYNC_PRESET, TOGGLE_MODE};
      end else begin
        st_nxt.prdata_r = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ctrl_r <= `JKTF_CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  jktf_cell u_cell (
    .pclk(pclk),
    .chip_wide_init(init_net),
    .cfg(cfg),
    .din(st_r.in_r),
    .q(state_q)
  );

  // no wait state: answer lands in the first access cycle
  assign pready = st_r.pready_r;
  assign prdata = st_r.prdata_r;
  assign pslverr = 1'b0;
endmodule

// file: inc/jktf_consts.svh
// constants for the jk/toggle flop family
`ifndef JKTF_CONSTS_SVH
`define JKTF_CONSTS_SVH
`define JKTF_APB_ADDR_W 12
`define JKTF_REG_CTRL 12'h000
`define JKTF_REG_INPUTS 12'h004
`define JKTF_REG_STATE 12'h008
`define JKTF_REG_CONFIG 12'h00c
`define JKTF_CTRL_MODE_BIT 0
`define JKTF_CTRL_ASYNC_BIT 1
`define JKTF_CTRL_PRIO_BIT 2
`define JKTF_CTRL_GATE_BIT 3
`define JKTF_CTRL_LOAD_BIT 4
`define JKTF_CTRL_OVR_BIT 5
`define JKTF_CTRL_SYNC_BIT 6
`define JKTF_CTRL_RESET 7'h08
`define JKTF_INIT_STATE 1'b0
`endif

// file: inc/jktf_pkg.sv
// types for the jk/toggle flop family
package jktf_pkg;
  typedef enum logic [1:0] {
    JKTF_CLEAR_FIRST = 2'b00,
    JKTF_SET_FIRST = 2'b01
  } jktf_prio_t;

  // control inputs of one cell
  typedef struct packed {
    logic set_req;
    logic clr_req;
    logic gate;
    logic sync_clr;
    logic sync_set;
    logic load_sel;
    logic load_val;
    logic async_force_zero;
    logic async_force_one;
  } jktf_in_t;

  // cell configuration
  typedef struct packed {
    logic toggle_mode;
    logic async_preset;
    logic set_first;
    logic has_gate;
    logic has_load;
    logic load_over_gate;
    logic has_sync;
  } jktf_cfg_t;

  typedef struct packed {
    logic q;
  } jktf_cell_st_t;

  typedef struct packed {
    logic [6:0] ctrl_r;
    jktf_in_t in_r;
    logic pready_r;
    logic [31:0] prdata_r;
  } jktf_top_st_t;
endpackage

// file: verilog/jktf_next.sv
// next-state decode of one cell on a rising edge
`timescale 1ns/1ps
module jktf_next (
  input wire jktf_pkg::jktf_cfg_t cfg,
  input wire jktf_pkg::jktf_in_t din,
  input wire logic q,
  output logic q_nxt
);
  always_comb begin
    logic en;
    logic lp;
    logic ld;
    en = din.gate | ~cfg.has_gate;
    // load path only in toggle variants
    lp = cfg.has_load & cfg.toggle_mode;
    ld = lp & din.load_sel & (cfg.load_over_gate | en);
    q_nxt = q;
    if (cfg.has_sync && !cfg.set_first && din.sync_clr) begin
      q_nxt = 1'b0;
    end else if (cfg.has_sync && din.sync_set) begin
      q_nxt = 1'b1;
    end else if (cfg.has_sync && din.sync_clr) begin
      q_nxt = 1'b0;
    end else if (ld) begin
      q_nxt = din.load_val;
    end else if (lp && din.load_sel) begin
      q_nxt = q;
    end else if (!en) begin
      q_nxt = q;
    end else if (cfg.toggle_mode) begin
      q_nxt = din.set_req ? ~q : q;
    end else begin
      case ({din.set_req, din.clr_req})
        2'b00: q_nxt = q;
        2'b01: q_nxt = 1'b0;
        2'b10: q_nxt = 1'b1;
        2'b11: q_nxt = ~q;
        default: q_nxt = q;
      endcase
    end
  end
endmodule

// file: verilog/jktf_cell.sv
// one storage cell configured through its cfg port, with async force
`timescale 1ns/1ps
module jktf_cell (
  input wire logic pclk,
  input wire logic chip_wide_init,
  input wire jktf_pkg::jktf_cfg_t cfg,
  input wire jktf_pkg::jktf_in_t din,
  output logic q
);
  jktf_pkg::jktf_cell_st_t st_r;
  jktf_pkg::jktf_cell_st_t st_nxt;
  logic q_next;
  logic force_one;
  logic force_zero;

  jktf_next u_next (
    .cfg(cfg),
    .din(din),
    .q(st_r.q),
    .q_nxt(q_next)
  );

  // both forces settle in one process, so a preset swap never leaves a stale pair
  always_comb begin
    force_one = cfg.async_preset & (din.async_force_one | chip_wide_init);
    force_zero = ~cfg.async_preset & (din.async_force_zero | chip_wide_init);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.q = q_next;
  end

  // async forces act without the clock; constant values only
  always_ff @(posedge pclk or posedge force_one or posedge force_zero) begin
    if (force_zero) begin
      st_r <= '0;
    end else if (force_one) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule

// file: verification/jktf_sva.sv
// port assertions for the flop family top
`timescale 1ns/1ps
module jktf_sva #(
  parameter bit TOGGLE_MODE = 1'b0,
  parameter bit ASYNC_PRESET = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_wide_init,
  input wire logic state_q
);
  logic [6:0] ctl_r;
  logic wr;
  logic win;
  logic wctl;
  assign wr = psel && penable && pready && pwrite;
  assign win = wr && paddr[11:0] == 12'h004;
  assign wctl = wr && paddr[11:0] == 12'h000;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctl_r <= 7'h08;
    else if (wctl)
      ctl_r <= pwdata[6:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_access_a: assert property (psel && penable |-> pready) else $error("no ready");
  no_error_a: assert property (!pslverr) else $error("error response");
  init_zero_a: assert property (
    wctl && !pwdata[1] && !ASYNC_PRESET ##1 chip_wide_init [*2] |-> !state_q) else $error("init");
  init_one_a: assert property (
    wctl && pwdata[1] ##1 chip_wide_init [*2] |-> state_q) else $error("preset init");
  reset_state_a: assert property (
    $rose(presetn) && !chip_wide_init |-> state_q == ASYNC_PRESET) else $error("reset");
  idle_hold_a: assert property (
    win && pwdata[8:0] == 9'h000 ##1 !chip_wide_init && !penable ##1 !chip_wide_init
    |-> $stable(state_q)) else $error("hold");
  sync_clear_a: assert property (
    win && pwdata[5] && !pwdata[0] && ctl_r[6] && (!ctl_r[2] || !pwdata[4])
    ##1 !chip_wide_init && !penable ##1 !chip_wide_init |-> !state_q) else $error("clear");
  sync_set_a: assert property (
    win && pwdata[4] && !pwdata[1] && ctl_r[6] && (ctl_r[2] || !pwdata[5])
    ##1 !chip_wide_init && !penable ##1 !chip_wide_init |-> state_q) else $error("set");
endmodule
bind jktf_top jktf_sva #(.TOGGLE_MODE(TOGGLE_MODE), .ASYNC_PRESET(ASYNC_PRESET)) u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .chip_wide_init, .state_q);

// file: verification/jktf_user.sv
// surrounding logic that drives the init net
`timescale 1ns/1ps
module jktf_user (
  input wire logic pclk,
  input wire logic init_n,
  output logic chip_wide_init
);
  always_ff @(posedge pclk)
    chip_wide_init <= !init_n;
endmodule

// file: verification/jktf_top_tb.sv
// self-checking bench with a reference flop model
`timescale 1ns/1ps
module jktf_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, init_n = 1;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r, d, rs = 32'h0000_004d;
  logic pready, pslverr, chip_wide_init, state_q, mq = 0, s = 0, sq = 0;
  logic [6:0] mc = 7'h08;
  logic [8:0] mi = 0;
  int miscompares = 0, num_checks = 0;
  jktf_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chip_wide_init, .state_q);
  jktf_user u_usr (.pclk, .init_n, .chip_wide_init);
  initial forever #20 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic logic hold(input logic q);
    if (chip_wide_init || (mc[1] ? mi[0] : mi[1]))
      return mc[1];
    return q;
  endfunction
  function automatic logic nx(input logic q);
    logic e;
    e = !mc[3] || mi[6];
    if (mc[6] && (mi[5] || mi[4]))
      return mc[2] ? mi[4] : !mi[5];
    if (!mc[0])
      return e ? (mi[8] ? (!mi[7] || !q) : (q && !mi[7])) : q;
    if (mc[4] && mi[3])
      return (mc[5] || e) ? mi[2] : q;
    return (e && mi[8]) ^ q;
  endfunction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc <= 7'h08;
      mi <= 0;
      mq <= 0;
    end else begin
      mq <= hold(nx(mq));
      if (psel && penable && pready && pwrite && paddr[11:0] == 12'h000)
        mc <= pwdata[6:0];
      if (psel && penable && pready && pwrite && paddr[11:0] == 12'h004)
        mi <= pwdata[8:0];
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {20'h0_0000, a};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    // state as the slave samples it at the setup edge
    s = sq;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  always @(negedge pclk) begin
    sq = hold(mq);
    if (presetn)
      chk(state_q, sq);
  end
  initial begin
    #600000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk(r, 32'h0000_0008);
    apb(0, 12'h00c, 0);
    chk(r, 0);
    apb(0, 12'h010, 0);
    chk(r, 0);
    for (int k = 0; k < 600; k++) begin
      rs = xs(rs);
      d = rs >> 8;
      // async forces are rare so clocked behaviour gets seen; mode bits stay free
      if (rs[5:3] != 0 && rs[1:0] == 2'b01)
        d[1:0] = 0;
      // init bits kept apart from the written bits so preset with init occurs
      init_n <= rs[31:28] != 0;
      apb(1, {rs[1:0], 2'b00}, d);
      apb(0, 12'h000, 0);
      chk(r, {25'h0, mc});
      apb(0, 12'h004, 0);
      chk(r, {23'h0, mi});
      apb(0, 12'h008, 0);
      chk(r, {31'h0, s});
      if (k == 300) begin
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
      end
    end
    conclude;
  end
endmodule
